// ### shared/drb_pkg.sv
// Constants shared by the DRAM read burst timing block and its testbench.
package drb_pkg;

	// ------------------------------------------------------------
	// Data and address layout
	// ------------------------------------------------------------
	localparam int WORD_W = 8;
	localparam int LINE_WORDS = 8;
	localparam int LINE_W = WORD_W * LINE_WORDS;
	localparam int ADDR_W = 15;
	localparam int A12_BIT = 12;
	localparam int COL_LSB_W = 3;
	localparam int CL_W = 4;
	localparam int RL_W = 5;
	localparam int PIPE_LEN = 32;
	localparam int FIFO_DEPTH = 32;

	// ------------------------------------------------------------
	// Command codes on the command pins
	// ------------------------------------------------------------
	localparam logic [2:0] CMD_NOP = 3'h0;
	localparam logic [2:0] CMD_RD = 3'h1;
	localparam logic [2:0] CMD_RDA = 3'h2;
	localparam logic [2:0] CMD_WR = 3'h3;
	localparam logic [2:0] CMD_WRA = 3'h4;

	// ------------------------------------------------------------
	// Mode fields
	// ------------------------------------------------------------
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	localparam logic [1:0] AL_ZERO = 2'h0;
	localparam logic [1:0] AL_CL1 = 2'h1;
	localparam logic [1:0] AL_CL2 = 2'h2;
	localparam logic [CL_W-1:0] CL_ONE = 4'h1;
	localparam logic [CL_W-1:0] CL_TWO = 4'h2;

	// ------------------------------------------------------------
	// Timing counts in link clock cycles
	// ------------------------------------------------------------
	localparam logic [2:0] TCCD_NCK = 3'h4;
	localparam logic [2:0] CYC_BL8 = 3'h4;
	localparam logic [2:0] CYC_BC4 = 3'h2;
	localparam logic [RL_W-1:0] PRE_LEAD = 5'h2;
	localparam logic [RL_W-1:0] DAT_LEAD = 5'h1;
	localparam logic [RL_W-1:0] RL_RESET = 5'h5;

endpackage

// ### rtl/drb_afifo.sv
// Two-clock line buffer with gray-coded pointers and registered flags.
`timescale 1ns/1ps

module drb_afifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 32
) (
	input wire logic i_wclk,
	input wire logic i_wrst,
	input wire logic i_wvalid,
	input wire logic [WIDTH-1:0] i_wdata,
	output logic o_wready,
	input wire logic i_rclk,
	input wire logic i_rrst,
	output logic o_rvalid,
	output logic [WIDTH-1:0] o_rdata,
	input wire logic i_rready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wbin_reg;
	logic [AW:0] wgray_reg;
	logic [AW:0] rbin_reg;
	logic [AW:0] rgray_reg;
	logic [AW:0] r2w_q1_reg;
	logic [AW:0] r2w_q2_reg;
	logic [AW:0] w2r_q1_reg;
	logic [AW:0] w2r_q2_reg;

	// ------------------------------------------------------------
	// Write side
	// ------------------------------------------------------------
	wire push = i_wvalid & o_wready;
	wire [AW:0] wbin_next = wbin_reg + {{AW{1'b0}}, push};
	wire [AW:0] wgray_next = (wbin_next >> 1) ^ wbin_next;
	wire [AW:0] rgray_full = {~r2w_q2_reg[AW:AW-1], r2w_q2_reg[AW-2:0]};
	wire full_next = (wgray_next == rgray_full);

	always_ff @(posedge i_wclk) begin
		if (push) begin
			mem[wbin_reg[AW-1:0]] <= i_wdata;
		end
	end

	always_ff @(posedge i_wclk) begin
		r2w_q1_reg <= rgray_reg;
		r2w_q2_reg <= r2w_q1_reg;
	end

	always_ff @(posedge i_wclk) begin
		if (i_wrst) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
			o_wready <= 1'b1;
		end else begin
			wbin_reg <= wbin_next;
			wgray_reg <= wgray_next;
			o_wready <= ~full_next;
		end
	end

	// ------------------------------------------------------------
	// Read side
	// ------------------------------------------------------------
	wire pop = i_rready & o_rvalid;
	wire [AW:0] rbin_next = rbin_reg + {{AW{1'b0}}, pop};
	wire [AW:0] rgray_next = (rbin_next >> 1) ^ rbin_next;
	wire empty_next = (rgray_next == w2r_q2_reg);

	assign o_rdata = mem[rbin_reg[AW-1:0]];

	always_ff @(posedge i_rclk) begin
		w2r_q1_reg <= wgray_reg;
		w2r_q2_reg <= w2r_q1_reg;
	end

	always_ff @(posedge i_rclk) begin
		if (i_rrst) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
			o_rvalid <= 1'b0;
		end else begin
			rbin_reg <= rbin_next;
			rgray_reg <= rgray_next;
			o_rvalid <= ~empty_next;
		end
	end

endmodule // drb_afifo

// ### rtl/drb_read_burst.sv
// Read burst timing core of a DDR3-class DRAM, fed by a two-clock line buffer.
`timescale 1ns/1ps

module drb_read_burst #(
	parameter int FIFO_DEPTH_P = drb_pkg::FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_line_valid,
	input wire logic [drb_pkg::LINE_W-1:0] i_line_data,
	output logic o_line_ready,
	input wire logic i_ck,
	input wire logic i_dll_locked,
	input wire logic [2:0] i_cmd,
	input wire logic [drb_pkg::ADDR_W-1:0] i_addr,
	input wire logic [1:0] i_bl_mode,
	input wire logic [drb_pkg::CL_W-1:0] i_cl,
	input wire logic [1:0] i_al_mode,
	output logic o_dqs_oe,
	output logic o_dq_oe,
	output logic [drb_pkg::WORD_W-1:0] o_dq_rise,
	output logic [drb_pkg::WORD_W-1:0] o_dq_fall,
	output logic o_underrun,
	output logic o_cmd_refused,
	output logic o_wr_bl8
);
	import drb_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PRE,
		ST_DATA
	} drb_state_t;

	// ------------------------------------------------------------
	// Link side reset and lock synchronisers
	// ------------------------------------------------------------
	logic rst_q1_reg;
	logic rst_l_reg;
	logic lock_q1_reg;
	logic lock_q2_reg;

	always_ff @(posedge i_ck) begin
		rst_q1_reg <= i_rst;
		rst_l_reg <= rst_q1_reg;
	end

	always_ff @(posedge i_ck) begin
		lock_q1_reg <= i_dll_locked;
		lock_q2_reg <= lock_q1_reg;
	end

	// ------------------------------------------------------------
	// Line buffer between the array side and the link
	// ------------------------------------------------------------
	logic fifo_rvalid;
	logic [LINE_W-1:0] fifo_rdata;
	logic dat_hit;

	drb_afifo #(
		.WIDTH(LINE_W),
		.DEPTH(FIFO_DEPTH_P)
	) u_buf (
		.i_wclk(i_clk),
		.i_wrst(i_rst),
		.i_wvalid(i_line_valid),
		.i_wdata(i_line_data),
		.o_wready(o_line_ready),
		.i_rclk(i_ck),
		.i_rrst(rst_l_reg),
		.o_rvalid(fifo_rvalid),
		.o_rdata(fifo_rdata),
		.i_rready(dat_hit)
	);

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	logic [2:0] gap_reg;

	// Auto precharge variants decode to the same column access.
	wire is_rd = (i_cmd == CMD_RD) | (i_cmd == CMD_RDA);
	wire is_wr = (i_cmd == CMD_WR) | (i_cmd == CMD_WRA);

	// Bit 12 only steers burst length; the column takes bits below it.
	wire a12 = i_addr[A12_BIT];
	wire [COL_LSB_W-1:0] col_lsb = i_addr[COL_LSB_W-1:0];

	wire otf_bl8 = (i_bl_mode == BL_OTF) & a12;
	wire fixed_bl8 = (i_bl_mode == BL_FIXED8);
	wire cmd_bl8 = fixed_bl8 | otf_bl8;

	// Column commands closer than the spacing are dropped.
	wire spaced = (gap_reg >= TCCD_NCK);
	// A read also needs the synchronised lock; a write only needs the spacing.
	wire rd_take = is_rd & spaced & lock_q2_reg;
	wire wr_take = is_wr & spaced;
	wire col_take = rd_take | wr_take;
	wire rd_refused = is_rd & ~rd_take;
	wire wr_refused = is_wr & ~wr_take;
	wire refuse = rd_refused | wr_refused;

	wire [2:0] gap_inc = gap_reg + 3'h1;
	wire [2:0] gap_hold = spaced ? gap_reg : gap_inc;
	wire [2:0] gap_next = col_take ? 3'h1 : gap_hold;

	always_ff @(posedge i_ck) begin
		if (rst_l_reg) begin
			gap_reg <= TCCD_NCK;
		end else begin
			gap_reg <= gap_next;
		end
	end

	// ------------------------------------------------------------
	// Read latency from the mode inputs
	// ------------------------------------------------------------
	// The latency is registered every edge, so a mode change also moves the taps for reads already in flight.
	logic [RL_W-1:0] rl_reg;

	wire al_is_cl1 = (i_al_mode == AL_CL1);
	wire al_is_cl2 = (i_al_mode == AL_CL2);
	wire [CL_W-1:0] cl_less1 = i_cl - CL_ONE;
	wire [CL_W-1:0] cl_less2 = i_cl - CL_TWO;
	wire [CL_W-1:0] al_part = al_is_cl2 ? cl_less2 : cl_less1;
	wire [CL_W-1:0] al_val = (al_is_cl1 | al_is_cl2) ? al_part : '0;
	wire [RL_W-1:0] rl_next = {1'b0, i_cl} + {1'b0, al_val};

	always_ff @(posedge i_ck) begin
		if (rst_l_reg) begin
			rl_reg <= RL_RESET;
		end else begin
			rl_reg <= rl_next;
		end
	end

	// ------------------------------------------------------------
	// Latency pipeline of accepted reads
	// ------------------------------------------------------------
	// Stage k holds a read that was taken k edges ago, so several
	// reads can be in flight at once.
	logic [PIPE_LEN-1:0] pv_reg;
	logic [PIPE_LEN-1:0] pbl_reg;
	logic [COL_LSB_W-1:0] pcol_reg [PIPE_LEN];

	always_ff @(posedge i_ck) begin
		if (rst_l_reg) begin
			pv_reg <= '0;
		end else begin
			pv_reg <= {pv_reg[PIPE_LEN-2:0], rd_take};
		end
	end

	always_ff @(posedge i_ck) begin
		pbl_reg <= {pbl_reg[PIPE_LEN-2:0], cmd_bl8};
	end

	genvar g;
	generate
		for (g = 0; g < PIPE_LEN; g++) begin : g_pipe
			if (g == 0) begin : g_head
				always_ff @(posedge i_ck) begin
					pcol_reg[g] <= col_lsb;
				end
			end else begin : g_body
				always_ff @(posedge i_ck) begin
					pcol_reg[g] <= pcol_reg[g-1];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Latency taps
	// ------------------------------------------------------------
	// Taps sit one stage early because the pin registers add the final edge.
	wire [RL_W-1:0] pre_idx = rl_reg - PRE_LEAD;
	wire [RL_W-1:0] dat_idx = rl_reg - DAT_LEAD;
	wire pre_hit = pv_reg[pre_idx];
	assign dat_hit = pv_reg[dat_idx];
	wire dat_bl8 = pbl_reg[dat_idx];
	wire [COL_LSB_W-1:0] dat_col = pcol_reg[dat_idx];

	// ------------------------------------------------------------
	// Burst engine
	// ------------------------------------------------------------
	drb_state_t st_reg;
	drb_state_t st_next;
	logic [2:0] cnt_reg;
	logic [1:0] phase_reg;
	logic bl8_reg;
	logic have_reg;
	logic [COL_LSB_W-1:0] col_reg;
	logic [LINE_W-1:0] line_reg;

	wire in_data = (st_reg == ST_DATA);
	wire more = in_data & (cnt_reg > 3'h1);
	wire [2:0] cnt_load = dat_bl8 ? CYC_BL8 : CYC_BC4;
	wire [2:0] cnt_dec = cnt_reg - 3'h1;
	wire [2:0] cnt_run = more ? cnt_dec : 3'h0;
	wire [2:0] cnt_next = dat_hit ? cnt_load : cnt_run;

	// A new burst may start on the edge that ends the previous one.
	always_comb begin
		unique case (st_reg)
			ST_IDLE, ST_PRE: begin
				if (dat_hit) begin
					st_next = ST_DATA;
				end else if (pre_hit) begin
					st_next = ST_PRE;
				end else begin
					st_next = ST_IDLE;
				end
			end
			ST_DATA: begin
				if (dat_hit | more) begin
					st_next = ST_DATA;
				end else if (pre_hit) begin
					st_next = ST_PRE;
				end else begin
					st_next = ST_IDLE;
				end
			end
			default: begin
				st_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ck) begin
		if (rst_l_reg) begin
			st_reg <= ST_IDLE;
			cnt_reg <= 3'h0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
		end
	end

	// ------------------------------------------------------------
	// Burst attributes and line hold
	// ------------------------------------------------------------
	wire [1:0] phase_next = dat_hit ? 2'h0 : phase_reg + 2'h1;
	wire s_bl8 = dat_hit ? dat_bl8 : bl8_reg;
	wire s_have = dat_hit ? fifo_rvalid : have_reg;
	wire [COL_LSB_W-1:0] s_col = dat_hit ? dat_col : col_reg;
	wire [LINE_W-1:0] s_line = dat_hit ? fifo_rdata : line_reg;

	always_ff @(posedge i_ck) begin
		if (rst_l_reg) begin
			phase_reg <= 2'h0;
			bl8_reg <= 1'b0;
			have_reg <= 1'b0;
			col_reg <= '0;
		end else begin
			phase_reg <= phase_next;
			bl8_reg <= s_bl8;
			have_reg <= s_have;
			col_reg <= s_col;
		end
	end

	always_ff @(posedge i_ck) begin
		line_reg <= s_line;
	end

	// ------------------------------------------------------------
	// Word order within the burst
	// ------------------------------------------------------------
	// Eight-beat bursts wrap within the aligned group of eight words,
	// chopped ones within the addressed group of four.
	wire [2:0] beat_r = {phase_next, 1'b0};
	wire [2:0] beat_f = {phase_next, 1'b1};
	wire [2:0] idx8_r = s_col + beat_r;
	wire [2:0] idx8_f = s_col + beat_f;
	wire [1:0] low4_r = s_col[1:0] + beat_r[1:0];
	wire [1:0] low4_f = s_col[1:0] + beat_f[1:0];
	wire [2:0] idx4_r = {s_col[2], low4_r};
	wire [2:0] idx4_f = {s_col[2], low4_f};
	wire [2:0] idx_r = s_bl8 ? idx8_r : idx4_r;
	wire [2:0] idx_f = s_bl8 ? idx8_f : idx4_f;
	wire [WORD_W-1:0] word_r = s_line[idx_r*WORD_W +: WORD_W];
	wire [WORD_W-1:0] word_f = s_line[idx_f*WORD_W +: WORD_W];

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	wire run_next = (st_next == ST_DATA);
	wire drive_next = (st_next != ST_IDLE);
	wire word_ok = run_next & s_have;
	wire [WORD_W-1:0] dq_r_next = word_ok ? word_r : '0;
	wire [WORD_W-1:0] dq_f_next = word_ok ? word_f : '0;
	// An empty buffer at burst start still drives the burst, with zero words.
	wire under_next = dat_hit & ~fifo_rvalid;
	wire wr_bl8_next = wr_take ? cmd_bl8 : o_wr_bl8;

	always_ff @(posedge i_ck) begin
		if (rst_l_reg) begin
			o_dqs_oe <= 1'b0;
			o_dq_oe <= 1'b0;
		end else begin
			o_dqs_oe <= drive_next;
			o_dq_oe <= run_next;
		end
	end

	always_ff @(posedge i_ck) begin
		if (rst_l_reg) begin
			o_dq_rise <= '0;
			o_dq_fall <= '0;
		end else begin
			o_dq_rise <= dq_r_next;
			o_dq_fall <= dq_f_next;
		end
	end

	always_ff @(posedge i_ck) begin
		if (rst_l_reg) begin
			o_underrun <= 1'b0;
			o_cmd_refused <= 1'b0;
			o_wr_bl8 <= 1'b0;
		end else begin
			o_underrun <= under_next;
			o_cmd_refused <= refuse;
			o_wr_bl8 <= wr_bl8_next;
		end
	end

endmodule // drb_read_burst

// ### tb/drb_read_burst_monitor.sv
// Checker for read burst timing at the link pins.
`timescale 1ns/1ps
module drb_read_burst_monitor (
	input wire logic i_ck,
	input wire logic i_rst,
	input wire logic i_dll_locked,
	input wire logic [2:0] i_cmd,
	input wire logic [drb_pkg::ADDR_W-1:0] i_addr,
	input wire logic [1:0] i_bl_mode,
	input wire logic [drb_pkg::CL_W-1:0] i_cl,
	input wire logic [1:0] i_al_mode,
	input wire logic o_dqs_oe,
	input wire logic o_dq_oe,
	input wire logic [drb_pkg::WORD_W-1:0] o_dq_rise,
	input wire logic [drb_pkg::WORD_W-1:0] o_dq_fall,
	input wire logic o_cmd_refused,
	input wire logic o_wr_bl8
);
	import drb_pkg::*;
	wire rd = i_cmd == CMD_RD || i_cmd == CMD_RDA;
	wire wr = i_cmd == CMD_WR || i_cmd == CMD_WRA;
	wire rl5 = rd && i_cl == 4'h5 && i_al_mode == AL_ZERO;
	wire a12 = i_addr[A12_BIT];
	wire b8 = i_bl_mode == BL_FIXED8 || (i_bl_mode == BL_OTF && a12);
	wire b4 = i_bl_mode == BL_FIXED4 || (i_bl_mode == BL_OTF && !a12);
	logic rst_s1;
	logic rst_s2;
	// The reset input belongs to the other clock; stretch it over the link-side copy's delay.
	always_ff @(posedge i_ck) begin
		rst_s1 <= i_rst;
		rst_s2 <= rst_s1;
	end
	wire rst_ck = i_rst | rst_s1 | rst_s2;
	default clocking cb @(posedge i_ck); endclocking
	default disable iff (rst_ck);
	a_strobe_lead: assert property (rl5 ##1 !o_cmd_refused |-> ##4 o_dqs_oe ##1 o_dq_oe)
		else $error("strobe or data late");
	a_eight_release: assert property (rl5 && b8 ##1 (!o_cmd_refused && !rd)[*4] |->
		##1 o_dqs_oe ##1 o_dq_oe[*4] ##1 !o_dq_oe && !o_dqs_oe) else $error("bad eight burst");
	a_chop_release: assert property (rl5 && b4 ##1 (!o_cmd_refused && !rd)[*4] |->
		##2 o_dq_oe[*2] ##1 !o_dq_oe && !o_dqs_oe) else $error("bad chop burst");
	a_sum_latency: assert property (rd && i_cl == 4'h5 && i_al_mode == AL_CL1 ##1
		!o_cmd_refused |-> ##7 !o_dqs_oe ##1 o_dqs_oe && !o_dq_oe ##1 o_dq_oe)
		else $error("read latency wrong");
	a_cl2_latency: assert property (rd && i_cl == 4'h5 && i_al_mode == AL_CL2 ##1
		!o_cmd_refused |-> ##6 !o_dqs_oe ##1 o_dqs_oe && !o_dq_oe ##1 o_dq_oe)
		else $error("read latency with CL-2 wrong");
	a_close_refused: assert property ((rd || wr) ##1 (rd || wr) && !o_cmd_refused |->
		##1 o_cmd_refused) else $error("close command taken");
	a_unlock_refused: assert property (!i_dll_locked[*4] ##0 rd |=> o_cmd_refused)
		else $error("read taken while unlocked");
	a_dq_in_strobe: assert property (o_dq_oe |-> o_dqs_oe) else $error("data without strobe");
	a_idle_zero: assert property (!o_dq_oe |-> o_dq_rise == 8'h00 && o_dq_fall == 8'h00)
		else $error("words while idle");
	a_write_choice: assert property (wr && i_bl_mode == BL_OTF ##1 !o_cmd_refused |->
		o_wr_bl8 == $past(a12)) else $error("write burst choice wrong");
	c_seamless: cover property (rd ##4 rd ##1 !o_cmd_refused);
	c_chop: cover property (rl5 && b4);
	c_refused: cover property ($rose(o_cmd_refused));
endmodule // drb_read_burst_monitor

bind drb_read_burst drb_read_burst_monitor i_mon (.i_ck, .i_rst, .i_dll_locked, .i_cmd, .i_addr,
	.i_bl_mode, .i_cl, .i_al_mode, .o_dqs_oe, .o_dq_oe, .o_dq_rise, .o_dq_fall, .o_cmd_refused,
	.o_wr_bl8);

// ### tb/drb_ctrl_model.sv
// Controller-side model: issues column commands and captures read words.
`timescale 1ns/1ps
module drb_ctrl_model (
	input wire logic i_ck,
	input wire logic i_dq_oe,
	input wire logic [drb_pkg::WORD_W-1:0] i_dq_rise,
	input wire logic [drb_pkg::WORD_W-1:0] i_dq_fall,
	input wire logic i_underrun,
	input wire logic i_refused,
	output logic [2:0] o_cmd,
	output logic [drb_pkg::ADDR_W-1:0] o_addr
);
	import drb_pkg::*;
	logic [WORD_W-1:0] cap[$];
	int underruns = 0;
	int refusals = 0;
	initial begin
		o_cmd = CMD_NOP;
		o_addr = '0;
	end
	always @(posedge i_ck) begin
		if (i_dq_oe) begin
			cap.push_back(i_dq_rise);
			cap.push_back(i_dq_fall);
		end
		underruns += int'(i_underrun);
		refusals += int'(i_refused);
	end
	// A gap of one leaves the command up so the next one follows on the very next edge.
	task automatic issue(input logic [2:0] cmd, input logic [ADDR_W-1:0] addr, input int gap);
		@(posedge i_ck);
		o_cmd <= cmd;
		o_addr <= addr;
		if (gap > 1) begin
			@(posedge i_ck);
			o_cmd <= CMD_NOP;
			repeat (gap - 2) @(posedge i_ck);
		end
	endtask
endmodule // drb_ctrl_model

// ### tb/drb_read_burst_tb_top.sv
// Self-checking bench for the read burst timing block.
`timescale 1ns/1ps
module drb_read_burst_tb_top;
	import drb_pkg::*;
	logic i_clk, i_rst, i_ck, i_line_valid, i_dll_locked, o_line_ready, o_dqs_oe, o_dq_oe;
	logic o_underrun, o_cmd_refused, o_wr_bl8;
	logic [LINE_W-1:0] i_line_data;
	logic [CL_W-1:0] i_cl;
	logic [1:0] i_bl_mode, i_al_mode;
	logic [WORD_W-1:0] o_dq_rise, o_dq_fall;
	logic [2:0] i_cmd;
	logic [ADDR_W-1:0] i_addr;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int ref0;
	drb_read_burst #(.FIFO_DEPTH_P(4)) i_dut (.i_clk, .i_rst, .i_line_valid, .i_line_data,
		.o_line_ready, .i_ck, .i_dll_locked, .i_cmd, .i_addr, .i_bl_mode, .i_cl, .i_al_mode,
		.o_dqs_oe, .o_dq_oe, .o_dq_rise, .o_dq_fall, .o_underrun, .o_cmd_refused, .o_wr_bl8);
	drb_ctrl_model i_ctrl (.i_ck, .i_dq_oe(o_dq_oe), .i_dq_rise(o_dq_rise), .i_dq_fall(o_dq_fall),
		.i_underrun(o_underrun), .i_refused(o_cmd_refused), .o_cmd(i_cmd), .o_addr(i_addr));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		i_ck = 1'b0;
		#3.7;
		forever #6 i_ck = ~i_ck;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic push(input int n);
		@(posedge i_clk);
		i_line_valid <= 1'b1;
		for (int k = 0; k < 8; k++) i_line_data[8*k +: 8] <= {n[3:0], 4'(k)};
		@(posedge i_clk);
		i_line_valid <= 1'b0;
	endtask
	task automatic mode(input logic [1:0] bl, input logic [1:0] al);
		@(posedge i_ck);
		i_bl_mode <= bl;
		i_al_mode <= al;
	endtask
	task automatic run(input logic [2:0] cmd, input logic [ADDR_W-1:0] addr);
		i_ctrl.cap.delete();
		i_ctrl.issue(cmd, addr, 4);
		repeat (16) @(posedge i_ck);
	endtask
	// Words of line n in burst order from column c; a negative n expects zeros.
	task automatic burst(input int n, input logic [2:0] c, input bit chop, input int base);
		logic [2:0] col;
		for (int i = 0; i < (chop ? 4 : 8); i++) begin
			col = chop ? {c[2], c[1:0] + 2'(i)} : c + 3'(i);
			chk(i_ctrl.cap[base+i], n < 0 ? 8'h00 : {n[3:0], 1'b0, col});
		end
	endtask
	task automatic s_fill;
		for (int n = 0; n < 4; n++) push(n);
		repeat (2) @(posedge i_clk);
		chk(o_line_ready, 1'b0);
	endtask
	task automatic s_fixed8;
		mode(BL_FIXED8, AL_ZERO);
		run(CMD_RD, 15'h0002);
		chk(i_ctrl.cap.size(), 8);
		burst(0, 3'h2, 0, 0);
	endtask
	task automatic s_chop_ap;
		mode(BL_OTF, AL_ZERO);
		run(CMD_RDA, 15'h0005);
		chk(i_ctrl.cap.size(), 4);
		burst(1, 3'h5, 1, 0);
	endtask
	task automatic s_seamless;
		i_ctrl.cap.delete();
		i_ctrl.issue(CMD_RD, 15'h1ff7, 4);
		run(CMD_RD, 15'h1ff0);
		chk(i_ctrl.cap.size(), 16);
		burst(2, 3'h7, 0, 0);
		burst(3, 3'h0, 0, 8);
	endtask
	task automatic s_rl9;
		push(4);
		mode(BL_OTF, AL_CL1);
		run(CMD_RD, 15'h1003);
		chk(i_ctrl.cap.size(), 8);
		burst(4, 3'h3, 0, 0);
	endtask
	task automatic s_fixed4;
		push(5);
		mode(BL_FIXED4, AL_CL2);
		run(CMD_RD, 15'h1006);
		chk(i_ctrl.cap.size(), 4);
		burst(5, 3'h6, 1, 0);
	endtask
	task automatic s_writes;
		mode(BL_OTF, AL_ZERO);
		i_ctrl.issue(CMD_WR, 15'h1000, 4);
		chk(o_wr_bl8, 1'b1);
		ref0 = i_ctrl.refusals;
		i_ctrl.issue(CMD_WRA, 15'h0000, 1);
		run(CMD_RD, 15'h1000);
		chk(o_wr_bl8, 1'b0);
		chk(i_ctrl.refusals - ref0, 1);
		chk(i_ctrl.cap.size(), 0);
	endtask
	task automatic s_unlock;
		@(posedge i_ck);
		i_dll_locked <= 1'b0;
		repeat (4) @(posedge i_ck);
		ref0 = i_ctrl.refusals;
		run(CMD_RD, 15'h1000);
		chk(i_ctrl.refusals - ref0, 1);
		chk(i_ctrl.cap.size(), 0);
		i_dll_locked <= 1'b1;
		repeat (4) @(posedge i_ck);
	endtask
	task automatic s_underrun;
		ref0 = i_ctrl.underruns;
		run(CMD_RD, 15'h1000);
		chk(i_ctrl.underruns - ref0, 1);
		chk(i_ctrl.cap.size(), 8);
		burst(-1, 3'h0, 0, 0);
	endtask
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_sim;
		end
	end
	initial begin
		i_rst = 1'b1;
		i_line_valid = 1'b0;
		i_line_data = '0;
		i_dll_locked = 1'b1;
		i_cl = 4'h5;
		i_bl_mode = BL_FIXED8;
		i_al_mode = AL_ZERO;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (6) @(posedge i_ck);
		s_fill;
		s_fixed8;
		s_chop_ap;
		s_seamless;
		s_rl9;
		s_fixed4;
		s_writes;
		s_unlock;
		s_underrun;
		end_sim;
	end
endmodule // drb_read_burst_tb_top
